// ---- edge_sync_if.sv ----
`timescale 1ns/10ps
// Purpose: carries pin levels in and falling-edge pulses back out
// Assumes: pulses are one cycle wide in the system clock domain
// Notes:   used between the timer and its pin synchroniser
interface edge_sync_if;
  logic count_pin;    // raw count pin level
  logic trigger_pin;  // raw trigger pin level
  logic count_fall;   // one-cycle falling edge on count pin
  logic trigger_fall; // one-cycle falling edge on trigger pin
  modport sync (input count_pin, input trigger_pin, output count_fall, output trigger_fall);
  modport user (output count_pin, output trigger_pin, input count_fall, input trigger_fall);
endinterface : edge_sync_if

// ---- pin_edge_sync.sv ----
`timescale 1ns/10ps
// Purpose: two-stage synchroniser and falling-edge detector for both pins
// Assumes: pins are asynchronous to ref_clk_in
// Notes:   the first stage feeds only the second stage
module pin_edge_sync (
  input  wire logic  ref_clk_in,
  input  wire logic  reset_n_in,
  edge_sync_if.sync  pins
);
  logic [1:0] meta;  // first stage, read only by the second
  logic [1:0] stable; // second stage
  logic [1:0] last;   // previous stable level

  // synchronise both pins; reset high so no false edge at release
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      meta   <= 2'h3;
      stable <= 2'h3;
      last   <= 2'h3;
    end else begin
      meta   <= {pins.trigger_pin, pins.count_pin};
      stable <= meta;
      last   <= stable;
    end
  end

  // one pulse per detected high-to-low edge
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      pins.count_fall   <= 1'b0;
      pins.trigger_fall <= 1'b0;
    end else begin
      pins.count_fall   <= last[0] & ~stable[0];
      pins.trigger_fall <= last[1] & ~stable[1];
    end
  end
endmodule : pin_edge_sync

// ---- timer_two_capture_reload_baud.sv ----
`timescale 1ns/10ps
// Purpose: 16-bit timer with capture, auto-reload and baud-clock modes
// Assumes: registers on a plain strobe port, read data one cycle later
// Notes:   timer one overflow comes in as a pulse for the unused UART side
//
// Summary of operation
// - trigger edge captures whole counter in capture mode
// - timer mode counts clock divided by one/twelve
// - counter mode counts count pin falling edges
// - rollover outside baud mode sets overflow flag; interrupt request only if unmasked
// - capture mode needs capture select and run
// - trigger edges ignored unless external enable set
// - overflow reloads counter from reload pair, except in capture mode where it wraps to zero
// - auto-reload when capture select clear; run starts
// - enabled trigger edge also reloads in auto-reload
// - baud overflow reloads, pulses shift clock, no flag
// - baud select bits force auto-reload behaviour
// - each select routes timer or timer one overflows
// - UART bit rate is overflow rate over sixteen
// - baud timebase is clock divided by two
// - pin-driven baud rate follows pin frequency formula
// - enabled trigger edge sets external flag always
module timer_two_capture_reload_baud
  import timer_two_pkg::*;
(
  input  wire logic       ref_clk_in,         // system clock
  input  wire logic       reset_n_in,         // synchronous, active low
  input  wire logic [7:0] addr_in,            // register address
  input  wire logic [7:0] wdata_in,           // write data
  input  wire logic       wr_in,              // write strobe
  input  wire logic       rd_in,              // read strobe
  input  wire logic       external_count_pin_in,   // count pin
  input  wire logic       external_trigger_pin_in, // trigger pin
  input  wire logic       timer_one_ovf_in,   // timer one overflow pulse
  output logic [7:0]      rdata_out,          // read data
  output logic            irq_out,            // level interrupt
  output logic            rx_shift_clk_out,   // UART receive shift clock pulse
  output logic            tx_shift_clk_out    // UART transmit shift clock pulse
);
  edge_sync_if pins ();
  assign pins.count_pin   = external_count_pin_in;
  assign pins.trigger_pin = external_trigger_pin_in;

  pin_edge_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .pins       (pins)
  );

  logic [7:0]  timer_two_control;   // control and flags
  logic        clock_divide_select; // 1: undivided clock
  logic [1:0]  irq_mask;            // enables for external/overflow flags
  logic [15:0] counter;             // counter high:low bytes
  logic [15:0] reload_capture;      // reload/capture high:low
  logic [3:0]  prescale;            // system clock divider

  // decoded control fields
  logic capture_reload_select;
  logic counter_timer_select;
  logic run_control;
  logic external_enable;
  logic transmit_clock_select;
  logic receive_clock_select;
  logic baud_mode;
  logic capture_mode;
  logic tick;          // one count step this cycle
  logic overflow;      // rollover this cycle
  logic trigger_event; // accepted trigger edge
  logic [3:0] prescale_last;

  // one write decode shared by every register process; keeps the
  // strobe and address compare identical everywhere
  function automatic logic reg_write(input logic       wr,
                                     input logic [7:0] addr,
                                     input logic [7:0] target);
    return wr && (addr == target);
  endfunction : reg_write

  assign capture_reload_select = timer_two_control[bit_capture_reload];
  assign counter_timer_select  = timer_two_control[bit_counter_timer];
  assign run_control           = timer_two_control[bit_run];
  assign external_enable       = timer_two_control[bit_ext_enable];
  assign transmit_clock_select = timer_two_control[bit_tx_clock];
  assign receive_clock_select  = timer_two_control[bit_rx_clock];

  // either baud select forces reload behaviour over capture select
  assign baud_mode    = transmit_clock_select | receive_clock_select;
  assign capture_mode = capture_reload_select & ~baud_mode;

  // trigger edges only count while externally enabled
  assign trigger_event = pins.trigger_fall & external_enable;

  // divide choice: baud mode fixes two, else one or twelve
  always_comb begin
    if (baud_mode) begin
      prescale_last = div_two_last;
    end else if (clock_divide_select) begin
      prescale_last = div_zero;
    end else begin
      prescale_last = div_twelve_last;
    end
  end

  // pin edges or divided clock produce count steps
  always_comb begin
    if (!run_control) begin
      tick = 1'b0;
    end else if (counter_timer_select) begin
      tick = pins.count_fall;
    end else begin
      tick = (prescale >= prescale_last);
    end
  end

  assign overflow = tick & (counter == count_top);

  // prescaler runs only while the timer runs in timer mode
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      prescale <= div_zero;
    end else if (!run_control || counter_timer_select) begin
      prescale <= div_zero;
    end else if (prescale >= prescale_last) begin
      prescale <= div_zero;
    end else begin
      prescale <= prescale + 4'h1;
    end
  end

  // counter: software write, reload on overflow or trigger, or count
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      counter <= count_reset;
    end else if (reg_write(wr_in, addr_in, count_low_addr)) begin
      counter[7:0] <= wdata_in;
    end else if (reg_write(wr_in, addr_in, count_high_addr)) begin
      counter[15:8] <= wdata_in;
    end else if (overflow && !capture_mode) begin
      counter <= reload_capture;
    end else if (trigger_event && !capture_mode && run_control) begin
      counter <= reload_capture;
    end else if (tick) begin
      counter <= counter + 16'h0001;
    end
  end

  // reload/capture pair: software write or hardware capture
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      reload_capture <= count_reset;
    end else if (trigger_event && capture_mode && run_control) begin
      reload_capture <= counter;
    end else if (reg_write(wr_in, addr_in, reload_low_addr)) begin
      reload_capture[7:0] <= wdata_in;
    end else if (reg_write(wr_in, addr_in, reload_high_addr)) begin
      reload_capture[15:8] <= wdata_in;
    end
  end

  // control register: plain bits written, flags sticky with set winning
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      timer_two_control <= ctrl_reset;
    end else begin
      if (reg_write(wr_in, addr_in, ctrl_addr)) begin
        // writing zero clears a flag, writing one keeps it
        timer_two_control <= (wdata_in & ~flag_mask)
                           | (wdata_in & timer_two_control & flag_mask);
      end
      if (overflow && !baud_mode) begin
        timer_two_control[bit_ovf_flag] <= 1'b1;
      end
      if (trigger_event) begin
        timer_two_control[bit_ext_flag] <= 1'b1;
      end
    end
  end

  // divider select and interrupt mask registers
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      clock_divide_select <= 1'b0;
      irq_mask            <= 2'h0;
    end else begin
      if (reg_write(wr_in, addr_in, divider_addr)) begin
        clock_divide_select <= wdata_in[0];
      end
      if (reg_write(wr_in, addr_in, irq_mask_addr)) begin
        irq_mask <= wdata_in[bit_ovf_flag:bit_ext_flag];
      end
    end
  end

  // interrupt level follows unmasked flags; hardware never clears them
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(timer_two_control[bit_ovf_flag:bit_ext_flag] & irq_mask);
    end
  end

  // shift clock pulses: timer overflow or timer one per direction;
  // the UART divides these by sixteen, so bit rate follows overflow rate
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      rx_shift_clk_out <= 1'b0;
      tx_shift_clk_out <= 1'b0;
    end else begin
      rx_shift_clk_out <= receive_clock_select ? overflow : timer_one_ovf_in;
      tx_shift_clk_out <= transmit_clock_select ? overflow : timer_one_ovf_in;
    end
  end

  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      rdata_out <= zero_byte;
    end else if (rd_in) begin
      case (addr_in)
        ctrl_addr:        rdata_out <= timer_two_control;
        reload_low_addr:  rdata_out <= reload_capture[7:0];
        reload_high_addr: rdata_out <= reload_capture[15:8];
        count_low_addr:   rdata_out <= counter[7:0];
        count_high_addr:  rdata_out <= counter[15:8];
        divider_addr:     rdata_out <= {7'h00, clock_divide_select};
        irq_mask_addr:    rdata_out <= {irq_mask, 6'h00};
        default:          rdata_out <= zero_byte;
      endcase
    end else begin
      rdata_out <= zero_byte;
    end
  end
endmodule : timer_two_capture_reload_baud

// ---- timer_two_capture_reload_baud_tb.sv ----
`timescale 1ns/10ps
// Purpose: register-level bench for the second timer
// Assumes: read data sampled one cycle after the strobe
// Notes:   pin edges and timer one pulses come from the far-side model
module timer_two_capture_reload_baud_tb
  import timer_two_pkg::*;
;
  logic       clk, rst_n, wr, rd, irq, rxc, txc, cpin, tpin, t1;
  logic [7:0] addr, wdata, rdata, v;
  int         err_count, n_checks, cyc, n_tx;
  // free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  timer_two_capture_reload_baud u_dut (.ref_clk_in(clk), .reset_n_in(rst_n),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .external_count_pin_in(cpin), .external_trigger_pin_in(tpin),
    .timer_one_ovf_in(t1), .rdata_out(rdata), .irq_out(irq),
    .rx_shift_clk_out(rxc), .tx_shift_clk_out(txc));
  timer_two_far_side u_far (.ref_clk_in(clk), .count_pin_out(cpin),
    .trigger_pin_out(tpin), .t1_ovf_out(t1));
  // shift pulse counter and hang guard
  always @(posedge clk) begin
    cyc++;
    if (txc === 1'b1) n_tx++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrt
  // data is only valid in the cycle after the strobe
  task automatic rdv(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rdv
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    rdv(a, v);
    chk(v, exp);
  endtask : rdc
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdc(8'hC8, ctrl_reset);
    rdc(8'hCF, 8'h00);
    wrt(8'hC9, 8'hFF);
    rdc(8'hC9, 8'h00);
    // capture mode: an enabled trigger edge captures the count, count pin edges count up
    wrt(8'hCE, 8'h01);
    wrt(8'hC8, 8'h0B);
    wrt(8'hCC, 8'h34);
    wrt(8'hCD, 8'h12);
    wrt(8'hC8, 8'h0F);
    u_far.swing(1'b1);
    rdc(8'hCA, 8'h34);
    rdc(8'hCB, 8'h12);
    rdc(8'hC8, 8'h4F);
    repeat (3) u_far.swing(1'b0);
    rdc(8'hCC, 8'h37);
    wrt(8'hC8, 8'h07);
    u_far.swing(1'b1);
    rdc(8'hC8, 8'h07);
    rdc(8'hCA, 8'h34);
    // auto-reload: a trigger edge reloads from the captured pair
    wrt(8'hC8, 8'h0E);
    u_far.swing(1'b1);
    rdc(8'hCC, 8'h34);
    wrt(8'hCF, 8'h40);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    wrt(8'hC8, 8'h0E);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    // undivided timer rolls over often from a high reload value
    wrt(8'hC8, 8'h00);
    wrt(8'hCA, 8'hF0);
    wrt(8'hCB, 8'hFF);
    wrt(8'hCC, 8'hFE);
    wrt(8'hCD, 8'hFF);
    wrt(8'hCF, 8'h80);
    wrt(8'hC8, 8'h04);
    repeat (40) @(posedge clk);
    wrt(8'hC8, 8'h80);
    rdc(8'hC8, 8'h80);
    rdc(8'hCD, 8'hFF);
    chk({7'h00, irq}, 8'h01);
    // divide by twelve: about ten ticks in 120 cycles
    wrt(8'hCE, 8'h00);
    wrt(8'hCC, 8'h00);
    wrt(8'hCD, 8'h00);
    wrt(8'hC8, 8'h04);
    repeat (120) @(posedge clk);
    wrt(8'hC8, 8'h00);
    rdv(8'hCC, v);
    chk(8'(v inside {[8'h09:8'h0B]}), 8'h01);
    // baud: capture bit set but ignored, overflow every four cycles
    wrt(8'hCA, 8'hFE);
    wrt(8'hCC, 8'hFE);
    wrt(8'hCD, 8'hFF);
    wrt(8'hC8, 8'h35);
    n_tx = 0;
    repeat (64) @(posedge clk);
    chk(8'(n_tx inside {[15:17]}), 8'h01);
    rdc(8'hC8, 8'h35);
    wrt(8'hC8, 8'h3D);
    u_far.swing(1'b1);
    rdc(8'hC8, 8'h7D);
    wrt(8'hC8, 8'h00);
    // let a last baud pulse launched on the write edge drain first
    repeat (2) @(posedge clk);
    n_tx = 0;
    u_far.t1_pulse();
    repeat (2) @(posedge clk);
    chk(8'(n_tx), 8'h01);
    stop_test();
  end
endmodule : timer_two_capture_reload_baud_tb

// ---- timer_two_far_side.sv ----
`timescale 1ns/10ps
// Purpose: far side of the timer: count pin, trigger pin, timer one
// Assumes: pins idle high and move only just after clock edges
// Notes:   each level is held four cycles, longer than the synchroniser
module timer_two_far_side (
  input  wire logic ref_clk_in,
  output logic      count_pin_out,
  output logic      trigger_pin_out,
  output logic      t1_ovf_out
);
  // pins rest high, the overflow line low
  initial begin
    count_pin_out = 1'b1;
    trigger_pin_out = 1'b1;
    t1_ovf_out = 1'b0;
  end
  // one falling edge then back high; a shorter glitch could be lost
  task automatic swing(input logic trig);
    @(posedge ref_clk_in);
    if (trig) trigger_pin_out <= 1'b0;
    else count_pin_out <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    trigger_pin_out <= 1'b1;
    count_pin_out <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
  endtask : swing
  // single-cycle overflow pulse from the other timer
  task automatic t1_pulse;
    @(posedge ref_clk_in);
    t1_ovf_out <= 1'b1;
    @(posedge ref_clk_in);
    t1_ovf_out <= 1'b0;
  endtask : t1_pulse
endmodule : timer_two_far_side

// ---- timer_two_monitor.sv ----
`timescale 1ns/10ps
// Purpose: port checker for the second timer
// Assumes: software bits are shadowed from the write strobe
// Notes:   flags are internal, so only routing, transmit pulse width, readback and the fully masked interrupt are seen
module timer_two_monitor
  import timer_two_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic       timer_one_ovf_in,
  input wire logic [7:0] rdata_out,
  input wire logic       irq_out,
  input wire logic       rx_shift_clk_out,
  input wire logic       tx_shift_clk_out
);
  logic [5:0] ctl; // software bits of the control register
  logic [1:0] msk; // interrupt mask bits
  logic       div; // divide select
  wire rd_ctl = rd_in && addr_in == ctrl_addr;
  wire rd_msk = rd_in && addr_in == irq_mask_addr;
  wire rd_div = rd_in && addr_in == divider_addr;
  wire rd_unm = rd_in && !(addr_in inside {ctrl_addr, [reload_low_addr:irq_mask_addr]});
  // shadows update on the same edge as the register file
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      ctl <= 6'h00;
      msk <= 2'h0;
      div <= 1'b0;
    end else if (wr_in) begin
      if (addr_in == ctrl_addr) ctl <= wdata_in[5:0];
      if (addr_in == irq_mask_addr) msk <= wdata_in[7:6];
      if (addr_in == divider_addr) div <= wdata_in[0];
    end
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  idle_read_zero_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside its slot");
  unmapped_read_a: assert property ($past(rd_unm) |-> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  ctrl_readback_a: assert property ($past(rd_ctl) |-> rdata_out[5:0] == $past(ctl))
    else $error("control bits read back wrong");
  mask_readback_a: assert property ($past(rd_msk) |-> rdata_out[7:6] == $past(msk))
    else $error("mask bits read back wrong");
  divide_readback_a: assert property ($past(rd_div) |-> rdata_out[0] == $past(div))
    else $error("divide select read back wrong");
  tx_route_a: assert property (!$past(ctl[4]) |-> tx_shift_clk_out == $past(timer_one_ovf_in))
    else $error("transmit clock not from timer one");
  rx_route_a: assert property (!$past(ctl[5]) |-> rx_shift_clk_out == $past(timer_one_ovf_in))
    else $error("receive clock not from timer one");
  irq_masked_a: assert property ($past(msk) == 2'b00 |-> !irq_out)
    else $error("interrupt while fully masked");
  tx_pulse_a: assert property ($rose(tx_shift_clk_out) |=> $fell(tx_shift_clk_out))
    else $error("shift clock pulse too long");
  cover property ($fell(irq_out));
  cover property (rx_shift_clk_out);
  cover property ($past(rd_ctl));
endmodule : timer_two_monitor
bind timer_two_capture_reload_baud timer_two_monitor u_mon (.ref_clk_in, .reset_n_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .timer_one_ovf_in, .rdata_out, .irq_out,
  .rx_shift_clk_out, .tx_shift_clk_out);

// ---- timer_two_pkg.sv ----
// Purpose: constants shared by the second timer and its register port
// Assumes: one 125 MHz clock, byte-wide registers on a plain strobe port
// Notes:   offsets other than the control register are local choices
package timer_two_pkg;
  localparam logic [7:0] ctrl_addr        = 8'hC8; // control register
  localparam logic [7:0] reload_low_addr  = 8'hCA; // reload/capture low
  localparam logic [7:0] reload_high_addr = 8'hCB; // reload/capture high
  localparam logic [7:0] count_low_addr   = 8'hCC; // counter low byte
  localparam logic [7:0] count_high_addr  = 8'hCD; // counter high byte
  localparam logic [7:0] divider_addr     = 8'hCE; // clock divide select
  localparam logic [7:0] irq_mask_addr    = 8'hCF; // interrupt mask
  localparam logic [7:0] ctrl_reset       = 8'h00;
  localparam logic [7:0] zero_byte        = 8'h00;
  localparam int unsigned bit_capture_reload = 0;
  localparam int unsigned bit_counter_timer  = 1;
  localparam int unsigned bit_run            = 2;
  localparam int unsigned bit_ext_enable     = 3;
  localparam int unsigned bit_tx_clock       = 4;
  localparam int unsigned bit_rx_clock       = 5;
  localparam int unsigned bit_ext_flag       = 6;
  localparam int unsigned bit_ovf_flag       = 7;
  localparam logic [3:0] div_twelve_last = 4'hB; // prescale wraps after 12
  localparam logic [3:0] div_two_last    = 4'h1; // prescale wraps after 2
  localparam logic [3:0] div_zero        = 4'h0;
  localparam logic [15:0] count_top      = 16'hFFFF;
  localparam logic [15:0] count_reset    = 16'h0000;
  localparam logic [7:0]  flag_mask      = 8'hC0; // sticky flag bits
endpackage : timer_two_pkg
